// ===== hw/battery_gauge_flag_logic.v
// Overview of operation
// - Initial warning sets when remaining capacity falls below its set level.
// - Initial warning clears only when capacity rises above its clear level.
// - Final warning sets when remaining capacity falls below its set level.
// - Final set level of minus one disables setting the final warning.
// - Final warning clears above its clear level, only while it is set.
// - Internal short flag sets on relaxed-voltage short detection.
// - Tab disconnect flag sets when health monitoring sees a lost tab.
// - Load mode 0 selects constant current (default), 1 constant power.
// - Load mode is mirrored into a load model bit of control status.
// - Load select 0 to 6 picks the current model, default 1.
// - Select 0 uses previous discharge cycle average current register.
// - Select 4 uses design capacity over five; 5 host, 6 user rate.
// - Sixty-four bytes of user storage in two 32-byte blocks.
// - Power modes move automatically on events; host may request some.
`default_nettype none
`include "gauge_regs.vh"

module battery_gauge_flag_logic #(
  parameter CAP_W = 16,
  parameter FLASH_BYTES = 64,
  parameter [7:0] FLASH_SUBCLASS = 8'h3a
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurement results
  input wire cap_update,
  input wire [CAP_W-1:0] remaining_capacity_cmd,
  input wire [CAP_W-1:0] design_capacity,
  input wire [CAP_W-1:0] present_dsg_current,
  input wire [CAP_W-1:0] mean_current_cmd,
  input wire [CAP_W-1:0] filtered_current,
  input wire dsg_cycle_end,
  // Condition detectors, one-cycle pulses
  input wire short_detect,
  input wire tab_detect,
  // Power events
  input wire current_low,
  input wire wake_event,
  // Status outputs
  output wire soc_initial_warn_flag,
  output wire soc_final_warn_flag,
  output reg internal_short_flag,
  output reg tab_disconnect_flag,
  output reg load_model_status_bit,
  output reg [CAP_W-1:0] model_rate,
  output wire [1:0] power_state
);

  localparam IDX_W = 6;

  reg load_mode;
  reg [2:0] load_select;
  reg [CAP_W-1:0] init_set;
  reg [CAP_W-1:0] init_clr;
  reg [CAP_W-1:0] final_set;
  reg [CAP_W-1:0] final_clr;
  reg [CAP_W-1:0] rem_cap;
  reg [CAP_W-1:0] host_rate_cmd;
  reg [CAP_W-1:0] user_rate_current;
  reg [CAP_W-1:0] prev_cycle_current;
  reg [4:0] flash_ofs;
  reg flash_block;
  reg [7:0] flash_sub;
  reg sleep_en;
  reg deep_req;
  reg hib_req;
  reg [7:0] user_flash [0:FLASH_BYTES-1];
  reg [31:0] next_prdata;
  reg mapped;
  reg [CAP_W-1:0] next_rate;
  integer i;

  wire deep_ack;
  wire setup_ok = psel && penable && !pready;
  wire done = psel && penable && pready;
  wire wr = done && pwrite;
  wire [IDX_W-1:0] flash_idx = {flash_block, flash_ofs};
  wire sub_ok = flash_sub == FLASH_SUBCLASS;
  wire [CAP_W-1:0] c_rate = design_capacity / `C_RATE_DIV;

  // Threshold flags
  soc_threshold_flag #(
    .WIDTH(CAP_W)
  ) u_init_flag (
    .pclk(pclk),
    .presetn(presetn),
    .update(cap_update),
    .capacity(remaining_capacity_cmd),
    .set_level(init_set),
    .clear_level(init_clr),
    .set_disable(1'b0),
    .flag(soc_initial_warn_flag)
  );

  soc_threshold_flag #(
    .WIDTH(CAP_W)
  ) u_final_flag (
    .pclk(pclk),
    .presetn(presetn),
    .update(cap_update),
    .capacity(remaining_capacity_cmd),
    .set_level(final_set),
    .clear_level(final_clr),
    .set_disable(final_set == `FINAL_DISABLED),
    .flag(soc_final_warn_flag)
  );

  power_mode_ctrl u_power (
    .pclk(pclk),
    .presetn(presetn),
    .sleep_allowed(sleep_en),
    .deep_req(deep_req),
    .hib_req(hib_req),
    .current_low(current_low),
    .wake_event(wake_event),
    .state(power_state),
    .deep_ack(deep_ack)
  );

  // Read mux and address decode
  always @* begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OFS_CTRL_STATUS: begin
        next_prdata[`CS_LOAD_BIT] = load_model_status_bit;
        next_prdata[`CS_PWR_HI:`CS_PWR_LO] = power_state;
      end
      `OFS_FLAGS: begin
        next_prdata[`FLG_INIT] = soc_initial_warn_flag;
        next_prdata[`FLG_FINAL] = soc_final_warn_flag;
        next_prdata[`FLG_SHORT] = internal_short_flag;
        next_prdata[`FLG_TAB] = tab_disconnect_flag;
      end
      `OFS_CONFIG: begin
        next_prdata[`CFG_LOAD_MODE] = load_mode;
        next_prdata[`CFG_LSEL_HI:`CFG_LSEL_LO] = load_select;
      end
      `OFS_INIT_SET: next_prdata[CAP_W-1:0] = init_set;
      `OFS_INIT_CLR: next_prdata[CAP_W-1:0] = init_clr;
      `OFS_FINAL_SET: next_prdata[CAP_W-1:0] = final_set;
      `OFS_FINAL_CLR: next_prdata[CAP_W-1:0] = final_clr;
      `OFS_REM_CAP: next_prdata[CAP_W-1:0] = rem_cap;
      `OFS_HOST_RATE: next_prdata[CAP_W-1:0] = host_rate_cmd;
      `OFS_USER_RATE: next_prdata[CAP_W-1:0] = user_rate_current;
      `OFS_FLASH_CTRL: begin
        next_prdata[`FC_OFS_HI:`FC_OFS_LO] = flash_ofs;
        next_prdata[`FC_BLOCK] = flash_block;
        next_prdata[`FC_SUB_HI:`FC_SUB_LO] = flash_sub;
      end
      `OFS_FLASH_DATA: begin
        // Wrong subclass reads as zero
        if (sub_ok) begin
          next_prdata[7:0] = user_flash[flash_idx];
        end
      end
      `OFS_PWR_REQ: begin
        next_prdata[`PR_SLEEP_EN] = sleep_en;
        next_prdata[`PR_DEEP] = deep_req;
        next_prdata[`PR_HIB] = hib_req;
      end
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: pready follows one cycle into the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ok) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_mode <= `MODE_CC;
      load_select <= `RST_LSEL;
      init_set <= `RST_INIT_SET;
      init_clr <= `RST_INIT_CLR;
      final_set <= `RST_FINAL_SET;
      final_clr <= `RST_FINAL_CLR;
      host_rate_cmd <= `RST_RATE;
      user_rate_current <= `RST_RATE;
      sleep_en <= 1'b1;
      hib_req <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `OFS_CONFIG: begin
          load_mode <= pwdata[`CFG_LOAD_MODE];
          load_select <= pwdata[`CFG_LSEL_HI:`CFG_LSEL_LO];
        end
        `OFS_INIT_SET: init_set <= pwdata[CAP_W-1:0];
        `OFS_INIT_CLR: init_clr <= pwdata[CAP_W-1:0];
        `OFS_FINAL_SET: final_set <= pwdata[CAP_W-1:0];
        `OFS_FINAL_CLR: final_clr <= pwdata[CAP_W-1:0];
        `OFS_HOST_RATE: host_rate_cmd <= pwdata[CAP_W-1:0];
        `OFS_USER_RATE: user_rate_current <= pwdata[CAP_W-1:0];
        `OFS_PWR_REQ: begin
          sleep_en <= pwdata[`PR_SLEEP_EN];
          hib_req <= pwdata[`PR_HIB];
        end
        default: begin
        end
      endcase
    end
  end

  // Deep sleep request: hardware drops it once the state is entered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_req <= 1'b0;
    end else if (wr && paddr == `OFS_PWR_REQ) begin
      deep_req <= pwdata[`PR_DEEP];
    end else if (deep_ack) begin
      deep_req <= 1'b0;
    end
  end

  // Condition flags, write one to clear; a new detection wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_short_flag <= 1'b0;
      tab_disconnect_flag <= 1'b0;
    end else begin
      if (short_detect) begin
        internal_short_flag <= 1'b1;
      end else if (wr && paddr == `OFS_FLAGS && pwdata[`FLG_SHORT]) begin
        internal_short_flag <= 1'b0;
      end
      if (tab_detect) begin
        tab_disconnect_flag <= 1'b1;
      end else if (wr && paddr == `OFS_FLAGS && pwdata[`FLG_TAB]) begin
        tab_disconnect_flag <= 1'b0;
      end
    end
  end

  // Latest capacity report and last cycle's mean discharge current
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_cap <= {CAP_W{1'b0}};
      prev_cycle_current <= {CAP_W{1'b0}};
    end else begin
      if (cap_update) begin
        rem_cap <= remaining_capacity_cmd;
      end
      if (dsg_cycle_end) begin
        prev_cycle_current <= present_dsg_current;
      end
    end
  end

  // Load model rate selection
  always @* begin
    case (load_select)
      `LSEL_PREV: next_rate = prev_cycle_current;
      `LSEL_PRESENT: next_rate = present_dsg_current;
      `LSEL_MEAN: next_rate = mean_current_cmd;
      `LSEL_FILT: next_rate = filtered_current;
      `LSEL_CRATE: next_rate = c_rate;
      `LSEL_HOST: next_rate = host_rate_cmd;
      `LSEL_USER: next_rate = user_rate_current;
      default: next_rate = present_dsg_current;
    endcase
  end

  // Constant-power tables live elsewhere; rate reads zero in that mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      model_rate <= {CAP_W{1'b0}};
      load_model_status_bit <= `MODE_CC;
    end else begin
      load_model_status_bit <= load_mode;
      if (load_mode == `MODE_CC) begin
        model_rate <= next_rate;
      end else begin
        model_rate <= {CAP_W{1'b0}};
      end
    end
  end

  // Storage pointer: offset steps after each data access with matching subclass, wraps in block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ofs <= 5'h00;
      flash_block <= 1'b0;
      flash_sub <= 8'h00;
    end else if (wr && paddr == `OFS_FLASH_CTRL) begin
      flash_ofs <= pwdata[`FC_OFS_HI:`FC_OFS_LO];
      flash_block <= pwdata[`FC_BLOCK];
      flash_sub <= pwdata[`FC_SUB_HI:`FC_SUB_LO];
    end else if (done && paddr == `OFS_FLASH_DATA && sub_ok) begin
      flash_ofs <= flash_ofs + 5'h01;
    end
  end

  // User storage, two blocks of 32 bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < FLASH_BYTES; i = i + 1) begin
        user_flash[i] <= 8'h00;
      end
    end else if (wr && paddr == `OFS_FLASH_DATA && sub_ok) begin
      user_flash[flash_idx] <= pwdata[7:0];
    end
  end

endmodule

`default_nettype wire

// ===== inc/gauge_regs.vh
`ifndef GAUGE_REGS_VH
`define GAUGE_REGS_VH

// Register byte offsets
`define OFS_CTRL_STATUS 8'h00
`define OFS_FLAGS 8'h04
`define OFS_CONFIG 8'h08
`define OFS_INIT_SET 8'h0c
`define OFS_INIT_CLR 8'h10
`define OFS_FINAL_SET 8'h14
`define OFS_FINAL_CLR 8'h18
`define OFS_REM_CAP 8'h1c
`define OFS_HOST_RATE 8'h20
`define OFS_USER_RATE 8'h24
`define OFS_FLASH_CTRL 8'h28
`define OFS_FLASH_DATA 8'h2c
`define OFS_PWR_REQ 8'h30

// Flag word bits
`define FLG_INIT 0
`define FLG_FINAL 1
`define FLG_SHORT 2
`define FLG_TAB 3

// Control status word bits
`define CS_LOAD_BIT 0
`define CS_PWR_LO 1
`define CS_PWR_HI 2

// Configuration word fields
`define CFG_LOAD_MODE 0
`define CFG_LSEL_LO 1
`define CFG_LSEL_HI 3

// Flash control fields
`define FC_OFS_LO 0
`define FC_OFS_HI 4
`define FC_BLOCK 5
`define FC_SUB_LO 8
`define FC_SUB_HI 15

// Power request bits
`define PR_SLEEP_EN 0
`define PR_DEEP 1
`define PR_HIB 2

// Load model codes
`define MODE_CC 1'b0
`define MODE_CP 1'b1
`define LSEL_PREV 3'h0
`define LSEL_PRESENT 3'h1
`define LSEL_MEAN 3'h2
`define LSEL_FILT 3'h3
`define LSEL_CRATE 3'h4
`define LSEL_HOST 3'h5
`define LSEL_USER 3'h6

// Power states
`define PWR_NORMAL 2'h0
`define PWR_SLEEP 2'h1
`define PWR_DEEP 2'h2
`define PWR_LOWEST 2'h3

// Reset values
`define RST_LSEL 3'h1
`define RST_INIT_SET 16'h0096
`define RST_INIT_CLR 16'h00af
`define RST_FINAL_SET 16'h004b
`define RST_FINAL_CLR 16'h0064
`define RST_RATE 16'h0000
`define RST_PWR_REQ 3'h1
`define FINAL_DISABLED 16'hffff
`define C_RATE_DIV 16'h0005

`endif

// ===== hw/soc_threshold_flag.v
`default_nettype none

module soc_threshold_flag #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Capacity report
  input wire update,
  input wire [WIDTH-1:0] capacity,
  // Thresholds, two's complement
  input wire [WIDTH-1:0] set_level,
  input wire [WIDTH-1:0] clear_level,
  input wire set_disable,
  // Result
  output reg flag
);

  // Capacity is unsigned; thresholds signed so that -1 can sit below zero
  wire signed [WIDTH:0] cap_s = {1'b0, capacity};
  wire signed [WIDTH:0] set_s = {set_level[WIDTH-1], set_level};
  wire signed [WIDTH:0] clr_s = {clear_level[WIDTH-1], clear_level};
  wire below = cap_s < set_s;
  wire above = cap_s > clr_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (update) begin
      if (!set_disable && below) begin
        flag <= 1'b1;
      end else if (flag && above) begin
        flag <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/power_mode_ctrl.v
`default_nettype none
`include "gauge_regs.vh"

module power_mode_ctrl (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Host requests
  input wire sleep_allowed,
  input wire deep_req,
  input wire hib_req,
  // System events
  input wire current_low,
  input wire wake_event,
  // State
  output reg [1:0] state,
  output reg deep_ack
);

  reg [1:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      `PWR_NORMAL: begin
        if (sleep_allowed && current_low && !wake_event) begin
          next_state = `PWR_SLEEP;
        end
      end
      `PWR_SLEEP: begin
        if (wake_event || !current_low) begin
          next_state = `PWR_NORMAL;
        end else if (hib_req) begin
          next_state = `PWR_LOWEST;
        end else if (deep_req) begin
          next_state = `PWR_DEEP;
        end
      end
      `PWR_DEEP: begin
        if (wake_event || !current_low) begin
          next_state = `PWR_NORMAL;
        end else if (hib_req) begin
          next_state = `PWR_LOWEST;
        end
      end
      `PWR_LOWEST: begin
        // Only an explicit wake leaves the lowest state
        if (wake_event) begin
          next_state = `PWR_NORMAL;
        end
      end
      default: begin
        next_state = `PWR_NORMAL;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= `PWR_NORMAL;
      deep_ack <= 1'b0;
    end else begin
      state <= next_state;
      deep_ack <= (state == `PWR_SLEEP) && (next_state == `PWR_DEEP);
    end
  end

endmodule

`default_nettype wire

// ===== testbench/gauge_monitor.sv
`default_nettype none
module gauge_monitor #(
  parameter CAP_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Events
  input wire logic cap_update,
  input wire logic short_detect,
  input wire logic tab_detect,
  input wire logic wake_event,
  // Status
  input wire logic soc_initial_warn_flag,
  input wire logic soc_final_warn_flag,
  input wire logic internal_short_flag,
  input wire logic tab_disconnect_flag,
  input wire logic load_model_status_bit,
  input wire logic [CAP_W-1:0] model_rate,
  input wire logic [1:0] power_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_setup_ready: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_init_hold: assert property (
    !cap_update |=> $stable(soc_initial_warn_flag))
    else $error("initial flag moved without capacity");
  a_final_hold: assert property (
    !cap_update |=> $stable(soc_final_warn_flag))
    else $error("final flag moved without capacity");
  a_short_sets: assert property (
    short_detect |=> internal_short_flag)
    else $error("short flag not set");
  a_tab_sets: assert property (tab_detect |=> tab_disconnect_flag)
    else $error("tab flag not set");
  a_power_rate_zero: assert property (
    load_model_status_bit && $past(load_model_status_bit)
    |-> model_rate == '0)
    else $error("rate not zero in power mode");
  a_lowest_stays: assert property (
    power_state == 2'h3 && !wake_event |=> power_state == 2'h3)
    else $error("left lowest state without wake");

  c_final: cover property (soc_final_warn_flag);
  c_lowest: cover property (power_state == 2'h3);
  c_err: cover property (pslverr);
endmodule

bind battery_gauge_flag_logic gauge_monitor #(.CAP_W(CAP_W)) i_gauge_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cap_update(cap_update),
  .short_detect(short_detect), .tab_detect(tab_detect),
  .wake_event(wake_event), .soc_initial_warn_flag(soc_initial_warn_flag),
  .soc_final_warn_flag(soc_final_warn_flag),
  .internal_short_flag(internal_short_flag),
  .tab_disconnect_flag(tab_disconnect_flag),
  .load_model_status_bit(load_model_status_bit),
  .model_rate(model_rate), .power_state(power_state)
);
`default_nettype wire

// ===== testbench/apb_host.sv
`default_nettype none
module apb_host (
  // Clock
  input wire logic pclk,
  // Requests
  output var logic [7:0] paddr,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [31:0] pwdata,
  // Answers
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic err;

  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end

  // Held until ready; only the bench timeout ends a stuck wait
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none
`include "gauge_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary storage subclass
  localparam logic [7:0] SUB = 8'h3a;
  logic pclk, presetn, cap_update, dsg_cycle_end, short_detect, tab_detect;
  logic current_low, wake_event;
  logic [15:0] rem_cap, design_cap, present_cur, mean_cur, filt_cur;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire psel, penable, pwrite, pready, pslverr;
  wire init_flag, final_flag, short_flag, tab_flag, load_bit;
  wire [15:0] model_rate;
  wire [1:0] power_state;
  int err_count, comparisons, cycles;
  logic [15:0] caps [6] = '{16'h95, 16'haf, 16'hb0, 16'h4a, 16'h64, 16'h65};
  logic [5:0] exp_init = 6'b111011;
  logic [5:0] exp_final = 6'b011000;
  logic [15:0] rates [8] = '{16'h77, 16'h11, 16'h22, 16'h33, 16'h14,
                             16'h55, 16'h66, 16'h11};

  apb_host i_apb_host (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  battery_gauge_flag_logic #(.FLASH_SUBCLASS(SUB)) i_battery_gauge_flag_logic (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_update(cap_update),
    .remaining_capacity_cmd(rem_cap), .design_capacity(design_cap),
    .present_dsg_current(present_cur), .mean_current_cmd(mean_cur),
    .filtered_current(filt_cur), .dsg_cycle_end(dsg_cycle_end),
    .short_detect(short_detect), .tab_detect(tab_detect),
    .current_low(current_low), .wake_event(wake_event),
    .soc_initial_warn_flag(init_flag), .soc_final_warn_flag(final_flag),
    .internal_short_flag(short_flag), .tab_disconnect_flag(tab_flag),
    .load_model_status_bit(load_bit), .model_rate(model_rate),
    .power_state(power_state));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task test_done;
    $display("compares %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Far longer than the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_host.xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    i_apb_host.xfer(1'b0, a, 32'h0);
    chk(i_apb_host.rdata, exp, m);
  endtask

  task cap(input logic [15:0] v);
    @(posedge pclk);
    rem_cap <= v;
    cap_update <= 1'b1;
    @(posedge pclk);
    cap_update <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_chk_state(input logic [1:0] s);
    repeat (3) @(posedge pclk);
    chk(power_state, s, "power state");
  endtask

  initial begin
    presetn = 1'b0;
    {cap_update, dsg_cycle_end, short_detect, tab_detect} = 4'h0;
    {current_low, wake_event} = 2'b00;
    rem_cap = 16'h0;
    design_cap = 16'h64;
    present_cur = 16'h77;
    mean_cur = 16'h22;
    filt_cur = 16'h33;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CONFIG, {28'h0, `RST_LSEL, 1'b0}, "cfg reset");
    rd(`OFS_INIT_CLR, {16'h0, `RST_INIT_CLR}, "clear reset");
    rd(8'h40, 32'h0, "unmapped read");
    chk(i_apb_host.err, 1'b1, "unmapped error");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      cap(caps[i]);
      chk(init_flag, exp_init[i], "init flag");
      chk(final_flag, exp_final[i], "final flag");
    end
    rd(`OFS_FLAGS, 32'h1, "flag word");
    wr(`OFS_FINAL_SET, 32'hffff);
    cap(16'h0);
    chk(final_flag, 1'b0, "final disabled");
    wr(`OFS_REM_CAP, 32'h1234);
    rd(`OFS_REM_CAP, 32'h0, "capacity read only");
    $display("test thresholds done");
    @(posedge pclk);
    short_detect <= 1'b1;
    @(posedge pclk);
    short_detect <= 1'b0;
    tab_detect <= 1'b1;
    @(posedge pclk);
    tab_detect <= 1'b0;
    @(posedge pclk);
    chk(short_flag, 1'b1, "short flag");
    chk(tab_flag, 1'b1, "tab flag");
    wr(`OFS_FLAGS, 32'hc);
    rd(`OFS_FLAGS, 32'h1, "condition clear");
    $display("test conditions done");
    @(posedge pclk);
    dsg_cycle_end <= 1'b1;
    @(posedge pclk);
    dsg_cycle_end <= 1'b0;
    present_cur <= 16'h11;
    wr(`OFS_HOST_RATE, 32'h55);
    wr(`OFS_USER_RATE, 32'h66);
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CONFIG, {28'h0, 3'(i), 1'b0});
      repeat (2) @(posedge pclk);
      chk(model_rate, rates[i], "rate");
    end
    wr(`OFS_CONFIG, 32'h1);
    repeat (2) @(posedge pclk);
    chk(load_bit, 1'b1, "load model bit");
    chk(model_rate, 16'h0, "power model rate");
    rd(`OFS_CTRL_STATUS, 32'h1, "control status");
    $display("test load model done");
    wr(`OFS_FLASH_CTRL, {16'h0, SUB, 8'h3f});
    wr(`OFS_FLASH_DATA, 32'ha5);
    wr(`OFS_FLASH_DATA, 32'h5a);
    wr(`OFS_FLASH_CTRL, {16'h0, SUB, 8'h3f});
    rd(`OFS_FLASH_DATA, 32'ha5, "storage last byte");
    rd(`OFS_FLASH_DATA, 32'h5a, "storage wrapped");
    wr(`OFS_FLASH_CTRL, {16'h0, SUB, 8'h1f});
    rd(`OFS_FLASH_DATA, 32'h0, "other block");
    wr(`OFS_FLASH_CTRL, 32'h3f);
    rd(`OFS_FLASH_DATA, 32'h0, "wrong subclass");
    $display("test storage done");
    @(posedge pclk);
    current_low <= 1'b1;
    wait_chk_state(`PWR_SLEEP);
    wr(`OFS_PWR_REQ, 32'h3);
    wait_chk_state(`PWR_DEEP);
    rd(`OFS_PWR_REQ, 32'h1, "deep request dropped");
    wr(`OFS_PWR_REQ, 32'h5);
    wait_chk_state(`PWR_LOWEST);
    rd(`OFS_CTRL_STATUS, 32'h7, "status in lowest");
    current_low <= 1'b0;
    wait_chk_state(`PWR_LOWEST);
    wake_event <= 1'b1;
    repeat (2) @(posedge pclk);
    wake_event <= 1'b0;
    chk(power_state, `PWR_NORMAL, "woken");
    $display("test power done");
    test_done;
  end
endmodule
`default_nettype wire
